//--- logic/nmba_adapter.v
// narrow memory byte lane adapter: splits operands into bus cycles
// ----------------------------------------
// Overview of operation
// - unaligned operand: high bytes moved first
// - narrow width request: low bytes first
// - 4-byte read at 16 bits: low half first
// - 3-byte part at 16 bits: halfword, byte, then low
// - line fill splits into up to sixteen cycles
// - later cycles within a fill word show remaining lanes only
// - never drive split select patterns
// - both width requests means 8 bits
// - 16-bit request gives two or three cycles
// - 8-bit request gives four byte cycles
// ----------------------------------------
`timescale 1ns/1ps
`include "nmba_defines.vh"
module nmba_adapter (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // logical request from the core side
    input wire req_valid,
    input wire [31:0] req_addr,
    input wire [2:0] req_len,
    input wire req_fill,
    output reg req_ready_q,
    output reg req_done_q,
    // bus cycle outputs
    output reg cyc_start_q,
    output reg [29:0] word_address_lines,
    output reg [3:0] byte_lane_selects_n,
    output reg [3:0] lanes_moved_q,
    // bus pins from outside, active low
    input wire cyc_ready_n,
    input wire width8_request_n,
    input wire width16_request_n
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg [2:0] sync1_q;  // first stage, read only by second
    reg [2:0] sync2_q;  // usable copies
    reg rdy_last_q;     // previous ready level for edge detect

    // hazard: a pin caught mid-change may settle late in the first
    // stage, so nothing but the second stage ever reads the first
    // two flops per pin; all pins share the same delay so width
    // requests line up with the ready they belong to
    always @(posedge mclk) begin
        if (!reset_n) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            rdy_last_q <= 1'b0;
        end else begin
            sync1_q <= {~cyc_ready_n, ~width8_request_n, ~width16_request_n};
            sync2_q <= sync1_q;
            rdy_last_q <= sync2_q[2];
        end
    end

    // rising edge of the active high ready; a held ready counts once
    wire rdy_edge;
    assign rdy_edge = sync2_q[2] & ~rdy_last_q;

    // ----------------------------------------
    // request decode
    // ----------------------------------------
    // span_mask covers eight lanes: bits 3:0 are the addressed word,
    // bits 7:4 the following word for an operand that crosses it
    // limitation: operands longer than four bytes are not split here,
    // the core side must hand them over one word at a time
    // byte span of the operand across two words
    reg [7:0] span_mask;
    reg [3:0] len_ones;

    always @* begin
        case (req_len)
            3'h1: len_ones = 4'h1;
            3'h2: len_ones = 4'h3;
            3'h4: len_ones = 4'hf;
            // other lengths treated as a single byte
            default: len_ones = 4'h1;
        endcase
        span_mask = {4'h0, len_ones} << req_addr[1:0];
    end

    // ----------------------------------------
    // lane stepping
    // ----------------------------------------
    // the stepper is pure logic on lanes_q and the synced width requests;
    // its result is only taken on the ready edge, so a width request that
    // wanders between cycles cannot tear a cycle in two
    reg [3:0] lanes_q;     // lanes still wanted in this portion
    wire [3:0] step_moved;
    wire [3:0] step_left;

    nmba_lane_step u_step (
        .lanes_wanted(lanes_q),
        .narrow8(sync2_q[1]),
        .narrow16(sync2_q[0]),
        .lanes_moved(step_moved),
        .lanes_left(step_left)
    );

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    // one operand at a time: idle accepts, wait walks the bus cycles
    // an operand has at most two portions (high word, then low word); a
    // line fill has four, one per word, each split further by width
    reg [1:0] state_q;      // idle or waiting on a bus cycle
    reg fill_q;             // current request is a line fill
    reg [1:0] parts_left_q; // portions after the current one
    reg [3:0] low_part_q;   // lanes of the low word of an unaligned operand

    always @(posedge mclk) begin
        if (!reset_n) begin
            state_q <= `NMBA_ST_IDLE;
            fill_q <= 1'b0;
            parts_left_q <= 2'h0;
            low_part_q <= `NMBA_NO_LANES;
            lanes_q <= `NMBA_NO_LANES;
            req_ready_q <= 1'b0;
            req_done_q <= 1'b0;
            cyc_start_q <= 1'b0;
            word_address_lines <= 30'h0;
            byte_lane_selects_n <= `NMBA_ALL_LANES;
            lanes_moved_q <= `NMBA_NO_LANES;
        end else begin
            // pulses default low
            req_done_q <= 1'b0;
            cyc_start_q <= 1'b0;
            lanes_moved_q <= `NMBA_NO_LANES;
            case (state_q)
                `NMBA_ST_IDLE: begin
                    req_ready_q <= 1'b1;
                    byte_lane_selects_n <= `NMBA_ALL_LANES;
                    if (req_valid && req_ready_q) begin
                        req_ready_q <= 1'b0;
                        cyc_start_q <= 1'b1;
                        state_q <= `NMBA_ST_WAIT;
                        fill_q <= req_fill;
                        if (req_fill) begin
                            // four words from the line base
                            parts_left_q <= `NMBA_FILL_WORDS;
                            word_address_lines <= {req_addr[31:4], 2'h0};
                            lanes_q <= `NMBA_ALL_LANES;
                            // first fill cycle shows every lane
                            byte_lane_selects_n <= `NMBA_NO_LANES;
                        end else if (span_mask[7:4] != `NMBA_NO_LANES) begin
                            parts_left_q <= 2'h1;
                            word_address_lines <= req_addr[31:2] + 30'h1;
                            lanes_q <= span_mask[7:4];
                            low_part_q <= span_mask[3:0];
                            byte_lane_selects_n <= ~span_mask[7:4];
                        end else begin
                            // aligned, one portion
                            parts_left_q <= 2'h0;
                            word_address_lines <= req_addr[31:2];
                            lanes_q <= span_mask[3:0];
                            byte_lane_selects_n <= ~span_mask[3:0];
                        end
                    end
                end
                // a ready held low counts once; the pin must rise between
                // cycles, which costs a cycle but never double counts
                `NMBA_ST_WAIT: begin
                    if (rdy_edge) begin
                        lanes_moved_q <= step_moved;
                        if (step_left != `NMBA_NO_LANES) begin
                            // remaining upper lanes in the next cycle
                            lanes_q <= step_left;
                            byte_lane_selects_n <= ~step_left;
                            cyc_start_q <= 1'b1;
                        end else if (parts_left_q != 2'h0) begin
                            parts_left_q <= parts_left_q - 2'h1;
                            cyc_start_q <= 1'b1;
                            if (fill_q) begin
                                // next word of the line, all lanes
                                word_address_lines <= word_address_lines + 30'h1;
                                lanes_q <= `NMBA_ALL_LANES;
                                byte_lane_selects_n <= `NMBA_NO_LANES;
                            end else begin
                                // low bytes of the operand last
                                word_address_lines <= word_address_lines - 30'h1;
                                lanes_q <= low_part_q;
                                byte_lane_selects_n <= ~low_part_q;
                            end
                        end else begin
                            // operand finished, release the bus
                            lanes_q <= `NMBA_NO_LANES;
                            byte_lane_selects_n <= `NMBA_ALL_LANES;
                            req_done_q <= 1'b1;
                            state_q <= `NMBA_ST_IDLE;
                        end
                    end
                end
                default: begin
                    // stray code recovers to idle
                    state_q <= `NMBA_ST_IDLE;
                end
            endcase
        end
    end

endmodule

//--- logic/nmba_defines.vh
// constants for the narrow memory byte lane adapter
`ifndef NMBA_DEFINES_VH
`define NMBA_DEFINES_VH

// ----------------------------------------
// sequencer state codes
// ----------------------------------------
`define NMBA_ST_IDLE 2'h0
`define NMBA_ST_WAIT 2'h1

// ----------------------------------------
// lane and line geometry
// ----------------------------------------
`define NMBA_LANES 4
`define NMBA_ALL_LANES 4'hf
`define NMBA_NO_LANES 4'h0
`define NMBA_LOW_HALF 4'h3
`define NMBA_FILL_WORDS 2'h3

`endif

//--- logic/nmba_lane_step.v
// lane stepper: lanes moved and lanes left after one bus cycle
`timescale 1ns/1ps
module nmba_lane_step (
    // lanes wanted this cycle, active high, contiguous
    input wire [3:0] lanes_wanted,
    // width requests seen at cycle end, active high
    input wire narrow8,
    input wire narrow16,
    // result
    output reg [3:0] lanes_moved,
    output reg [3:0] lanes_left
);

    // lowest wanted lane as a one-hot mask
    wire [3:0] lowest_lane;
    assign lowest_lane = lanes_wanted & (~lanes_wanted + 4'h1);

    // ----------------------------------------
    // width split
    // ----------------------------------------
    // removal always from the low end keeps the remainder contiguous
    always @* begin
        if (narrow8) begin
            lanes_moved = lowest_lane;
        end else if (narrow16) begin
            if ((lanes_wanted & `NMBA_LOW_HALF) != `NMBA_NO_LANES) begin
                lanes_moved = lanes_wanted & `NMBA_LOW_HALF;
            end else begin
                lanes_moved = lanes_wanted;
            end
        end else begin
            // full width, all in one cycle
            lanes_moved = lanes_wanted;
        end
        lanes_left = lanes_wanted & ~lanes_moved;
    end

endmodule

//--- tb/nmba_adapter_props.sv
// port assertions for the byte lane adapter
`timescale 1ns/1ps
module nmba_adapter_props (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // request side
    input wire req_valid,
    input wire req_ready_q,
    input wire req_done_q,
    // bus side
    input wire cyc_start_q,
    input wire [29:0] word_address_lines,
    input wire [3:0] byte_lane_selects_n,
    input wire [3:0] lanes_moved_q,
    input wire width8_request_n,
    input wire width16_request_n
);
    // selects of the cycle that just ended, kept so moved lanes can be judged
    reg [3:0] prev_q;
    wire [3:0] act = ~prev_q;
    wire [3:0] low1 = act & (~act + 4'h1);
    wire [3:0] half = ((act & 4'h3) != 4'h0) ? (act & 4'h3) : act;
    wire [3:0] rest = act & ~lanes_moved_q;
    wire mv = lanes_moved_q != 4'h0;
    always @(posedge mclk) prev_q <= byte_lane_selects_n;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_sel_contiguous: assert property (
        !(byte_lane_selects_n inside {4'h2, 4'h4, 4'h5, 4'h6, 4'ha})) else $error("split lanes");
    a_byte_narrow: assert property (
        mv && !width8_request_n |-> lanes_moved_q == low1) else $error("byte cycle lanes");
    a_half_narrow: assert property (
        mv && width8_request_n && !width16_request_n |-> lanes_moved_q == half)
        else $error("half cycle lanes");
    a_full_width: assert property (
        mv && width8_request_n && width16_request_n |-> lanes_moved_q == act)
        else $error("full cycle lanes");
    a_reissue_rest: assert property (
        mv && rest != 4'h0 |-> cyc_start_q && byte_lane_selects_n == ~rest
        && $stable(word_address_lines)) else $error("rest not reissued");
    a_end_step: assert property (mv |-> cyc_start_q != req_done_q) else $error("no next step");
    a_take_start: assert property (req_valid && req_ready_q |=> cyc_start_q && !req_ready_q)
        else $error("no start after take");
    a_done_ready: assert property (req_done_q |=> !req_done_q && req_ready_q)
        else $error("done not one pulse");
    a_idle_sel: assert property (req_ready_q |-> byte_lane_selects_n == 4'hf)
        else $error("selects active in idle");
endmodule
bind nmba_adapter nmba_adapter_props nmba_adapter_props_i (.mclk(mclk), .reset_n(reset_n),
    .req_valid(req_valid), .req_ready_q(req_ready_q), .req_done_q(req_done_q),
    .cyc_start_q(cyc_start_q), .word_address_lines(word_address_lines),
    .byte_lane_selects_n(byte_lane_selects_n), .lanes_moved_q(lanes_moved_q),
    .width8_request_n(width8_request_n), .width16_request_n(width16_request_n));

//--- tb/nmba_narrow_mem.sv
// far side model: decoder and narrow memory answering each bus cycle
`timescale 1ns/1ps
module nmba_narrow_mem (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // cycle from the adapter
    input wire cyc_start_q,
    input wire [3:0] lanes_moved_q,
    // target width and wait states
    input wire mode8,
    input wire mode16,
    input wire [3:0] slow,
    // pins back, active low
    output reg cyc_ready_n,
    output reg width8_request_n,
    output reg width16_request_n,
    // selects from the adapter
    input wire [3:0] byte_lane_selects_n,
    // decoded narrow bus address and strobes, strobes active low
    output wire halfword_address_bit,
    output wire byte_address_bit,
    output wire upper_byte_strobe_n,
    output wire lower_byte_strobe_n
);
    // byte select decoder for the narrow memories
    // plain gates, valid in the same cycle as the selects
    // split patterns never come, so their outputs fall anywhere
    // odd halfword when neither low lane is selected
    assign halfword_address_bit = byte_lane_selects_n[0] & byte_lane_selects_n[1];
    // lane 0, or lane 2 of an odd halfword
    assign lower_byte_strobe_n = byte_lane_selects_n[0]
        & (~byte_lane_selects_n[1] | byte_lane_selects_n[2]);
    // lane 1, or lane 3 of an odd halfword
    assign upper_byte_strobe_n = halfword_address_bit ? byte_lane_selects_n[3]
        : byte_lane_selects_n[1];
    // the byte bit is the lower strobe itself
    // data lane swapping follows these bits: odd halves sit on the upper lanes
    assign byte_address_bit = lower_byte_strobe_n;
    reg busy_q;
    reg [3:0] wait_q;
    // pins held until the move is reported, so the synchroniser sees them settled
    always @(posedge mclk) begin
        if (!reset_n || lanes_moved_q != 4'h0) begin
            cyc_ready_n <= 1'b1;
            // released pins float high, so full width
            width8_request_n <= 1'b1;
            width16_request_n <= 1'b1;
        end else if (busy_q && wait_q == 4'h0 && !cyc_start_q) begin
            cyc_ready_n <= 1'b0;
            // width request from the addressed target
            width8_request_n <= ~mode8;
            width16_request_n <= ~mode16;
        end
        if (!reset_n || !cyc_start_q && wait_q == 4'h0) begin
            busy_q <= 1'b0;
            wait_q <= 4'h0;
        end else if (cyc_start_q) begin
            busy_q <= 1'b1;
            wait_q <= slow;
        end else
            wait_q <= wait_q - 4'h1;
    end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the byte lane adapter
`timescale 1ns/1ps
module tb_top;
    reg mclk, reset_n, req_valid, req_fill, m8, m16;
    reg [31:0] req_addr;
    reg [2:0] req_len;
    reg [3:0] slow;
    wire ready, done, start, rdy_n, w8_n, w16_n;
    wire a1, a0, ub_n, lb_n;
    wire [29:0] wal;
    wire [3:0] sel_n, moved;
    reg [7:0] seen [0:31];
    reg [3:0] dec_seen [0:31];
    integer n_errors, num_checks, n_seen, i, t;
    nmba_adapter nmba_adapter_i (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid),
        .req_addr(req_addr), .req_len(req_len), .req_fill(req_fill), .req_ready_q(ready),
        .req_done_q(done), .cyc_start_q(start), .word_address_lines(wal),
        .byte_lane_selects_n(sel_n), .lanes_moved_q(moved), .cyc_ready_n(rdy_n),
        .width8_request_n(w8_n), .width16_request_n(w16_n));
    nmba_narrow_mem nmba_narrow_mem_i (.mclk(mclk), .reset_n(reset_n), .cyc_start_q(start),
        .lanes_moved_q(moved), .mode8(m8), .mode16(m16), .slow(slow), .cyc_ready_n(rdy_n),
        .width8_request_n(w8_n), .width16_request_n(w16_n), .byte_lane_selects_n(sel_n),
        .halfword_address_bit(a1), .byte_address_bit(a0), .upper_byte_strobe_n(ub_n),
        .lower_byte_strobe_n(lb_n));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // log word nibble and selects of every bus cycle, and the decoder view
    // a full width target takes word lines and selects as they stand
    always @(posedge mclk) begin
        if (start) begin
            seen[n_seen[4:0]] <= {wal[3:0], sel_n};
            dec_seen[n_seen[4:0]] <= {a1, a0, ub_n, lb_n};
            n_seen <= n_seen + 1;
        end
    end
    task check(input string what, input [7:0] exp, input [7:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("mismatch %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // decoder view per cycle {halfword, byte, upper_n, lower_n}, first cycle leftmost
    task check_dec(input [4:0] n, input [31:0] exp);
        begin
            for (i = 0; i < n; i = i + 1)
                check("decode", {4'h0, exp[4 * (n - 1 - i) +: 4]}, {4'h0, dec_seen[i]});
        end
    endtask
    // one request, wait for done, compare the cycle list (first cycle leftmost)
    task run(input [31:0] a, input [2:0] len, input f, input w8, input w16, input [4:0] n,
        input [127:0] exp);
        begin
            m8 <= w8;
            m16 <= w16;
            n_seen = 0;
            req_addr <= a;
            req_len <= len;
            req_fill <= f;
            req_valid <= 1'b1;
            t = 0;
            do begin @(posedge mclk); t = t + 1; end while (ready !== 1'b1 && t < 50);
            check("request taken", 8'h01, {7'h0, ready === 1'b1});
            req_valid <= 1'b0;
            t = 0;
            do begin @(posedge mclk); t = t + 1; end while (done !== 1'b1 && t < 600);
            check("operand done", 8'h01, {7'h0, done === 1'b1});
            check("cycle count", {3'h0, n}, n_seen[7:0]);
            for (i = 0; i < n; i = i + 1) check("cycle", exp[8 * (n - 1 - i) +: 8], seen[i]);
            $display("test at %h finished, %0d cycles", a, n);
        end
    endtask
    task t_word; run(32'h100, 3'h4, 1'b0, 1'b0, 1'b0, 5'd1, 8'h00); endtask
    task t_byte16; run(32'h102, 3'h1, 1'b0, 1'b0, 1'b1, 5'd1, 8'h0b); endtask
    task t_split16; run(32'h100, 3'h4, 1'b0, 1'b0, 1'b1, 5'd2, 16'h0003); endtask
    task t_split8;
        begin
            run(32'h100, 3'h4, 1'b0, 1'b1, 1'b0, 5'd4, 32'h00010307);
            check_dec(5'd4, 32'h0000058d);
        end
    endtask
    task t_both8; run(32'h100, 3'h4, 1'b0, 1'b1, 1'b1, 5'd4, 32'h00010307); endtask
    task t_unal32; run(32'h101, 3'h4, 1'b0, 1'b0, 1'b0, 5'd2, 16'h1e01); endtask
    task t_unal16;
        begin
            run(32'h103, 3'h4, 1'b0, 1'b0, 1'b1, 5'd3, 24'h181b07);
            check_dec(5'd3, 32'h000000ad);
        end
    endtask
    task t_fill8;
        begin
            slow <= 4'h3;
            run(32'h104, 3'h4, 1'b1, 1'b1, 1'b0, 5'd16,
                128'h00010307_10111317_20212327_30313337);
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_errors);
            if (n_errors == 0 && num_checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    initial begin
        {reset_n, req_valid, req_fill, m8, m16, req_addr, req_len, slow} = 0;
        n_errors = 0;
        num_checks = 0;
        n_seen = 0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_word;
        t_byte16;
        t_split16;
        t_split8;
        t_both8;
        t_unal32;
        t_unal16;
        t_fill8;
        give_verdict;
    end
    // watchdog: all tests need well under 1000 cycles
    initial begin
        #(100 * 4000);
        n_errors = n_errors + 1;
        give_verdict;
    end
endmodule
